//--- common/ccr_pkg.sv
// package for the calibration coefficient register bank
package ccr_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          REG_W          = 24;
    localparam int          GAIN_W         = 18;
    localparam int          OFS_W          = 20;
    localparam int          CHSEL_W        = 3;
    localparam logic [3:0]  ADDR_GAIN_COEFF_SET1     = 4'h8;
    localparam logic [3:0]  ADDR_GAIN_COEFF_SET2     = 4'h9;
    localparam logic [3:0]  ADDR_OFS1      = 4'hc;
    localparam logic [3:0]  ADDR_OFS2      = 4'hd;
    localparam logic [23:0] COEFF_RESET    = 24'h000000;
    localparam logic [2:0]  CHSEL_SET2_A   = 3'h2;
    localparam logic [2:0]  CHSEL_SET2_B   = 3'h3;

    typedef enum logic {CCR_SET1, CCR_SET2} ccr_set_t;
endpackage : ccr_pkg

//--- common/ccr_wr_if.sv
// interface carrying one register write from the top to a coefficient store
`timescale 1ns/10ps
`default_nettype none
interface ccr_wr_if;
    logic        en;
    logic [23:0] data;
    modport src (output en, output data);
    modport dst (input en, input data);
endinterface : ccr_wr_if
`default_nettype wire

//--- core/ccr_coeff_store.sv
// one coefficient register, either an 18-bit gain or a sign-extended 20-bit offset
`timescale 1ns/10ps
`default_nettype none
module ccr_coeff_store #(
    parameter int  VAL_W  = 20,
    parameter bit  SIGNED = 1'b1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    ccr_wr_if.dst             wr,
    output logic       [23:0] value
);
    import ccr_pkg::*;

    // the upper bits are derived, so a field wider than the word cannot be served
    if (VAL_W < 1 || VAL_W > REG_W) begin : g_bad_val_w
        $error("ccr_coeff_store: value width does not fit the register word");
    end

    logic [VAL_W-1:0] val_q;
    logic [VAL_W-1:0] val_d;

    assign val_d = wr.en ? wr.data[VAL_W-1:0] : val_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            val_q <= COEFF_RESET[VAL_W-1:0]; // [R01] [R08]
        end else begin
            val_q <= val_d; // [R02]
        end
    end

    // upper bits are never stored: they are derived, so software cannot break them
    generate
        if (SIGNED) begin : g_sext
            assign value = {{(REG_W-VAL_W){val_q[VAL_W-1]}}, val_q}; // [R03]
        end else begin : g_zext
            assign value = {{(REG_W-VAL_W){1'b0}}, val_q}; // [R08]
        end
    endgenerate
endmodule : ccr_coeff_store
`default_nettype wire

//--- core/ccr_bank.sv
// calibration coefficient register bank with set selection
// ----------------------------------------------------------------
// Notes on behaviour
// [R01] two 24-bit offset registers at 0xc and 0xd, zero after reset
// [R02] offset holds the latest of calibration result or host write
// [R03] offset is 20-bit two's complement, bits 23:20 copy the sign
// [R04] host offset writes accepted only while oscillator clock runs
// [R05] host clears auto sleep control before writing offsets
// [R06] positive input select codes 2 and 3 choose set 2, others set 1
// [R07] selected gain and offset pair drives result correction
// [R08] two 24-bit gain registers from 0x8, 18-bit unsigned, top six read 0
// [R09] host gain writes accepted only while oscillator clock runs
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module ccr_bank (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic [ccr_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [ccr_pkg::REG_W-1:0]     reg_wdata,
    output logic      [ccr_pkg::REG_W-1:0]     reg_rdata,
    input  wire logic                          osc_running,
    input  wire logic [ccr_pkg::CHSEL_W-1:0]   positive_input_select,
    input  wire logic                          cal_ofs_valid,
    input  wire logic [ccr_pkg::OFS_W-1:0]     cal_ofs_value,
    output logic      [ccr_pkg::REG_W-1:0]     sel_gain,
    output logic      [ccr_pkg::REG_W-1:0]     sel_offset,
    output logic                               sel_set2
);
    import ccr_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the stores derive the upper bits, so a field wider than the word cannot be served
    if (GAIN_W < 1 || GAIN_W > REG_W) begin : g_bad_gain_w
        $error("ccr_bank: gain width does not fit the register word");
    end
    if (OFS_W < 2 || OFS_W > REG_W) begin : g_bad_ofs_w
        $error("ccr_bank: offset width does not fit the register word");
    end
    if (CHSEL_W < 2) begin : g_bad_chsel_w
        $error("ccr_bank: select field too narrow for the set codes");
    end

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // true for the two select codes that route to the second coefficient set
    function automatic logic set2_of(input logic [CHSEL_W-1:0] c);
        return (c == CHSEL_SET2_A) || (c == CHSEL_SET2_B); // [R06]
    endfunction : set2_of

    // a qualified host write that lands on one given address
    function automatic logic hit_of(
        input logic              wr_ok,
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] target
    );
        return wr_ok && (a == target);
    endfunction : hit_of

    // widen a signed offset field to the register word
    function automatic logic [REG_W-1:0] sext_ofs(input logic [OFS_W-1:0] v);
        return {{(REG_W-OFS_W){v[OFS_W-1]}}, v}; // [R03]
    endfunction : sext_ofs

    // ----------------------------------------------------------------
    // host write qualification
    // ----------------------------------------------------------------
    // a write while the oscillator is stopped is dropped silently; the host gets no
    // error, so it must keep the clock alive itself before touching coefficients
    wire logic host_wr;
    assign host_wr = reg_wr & osc_running; // [R04] [R09]

    wire logic h_g1;
    wire logic h_g2;
    wire logic h_o1;
    wire logic h_o2;
    assign h_g1 = hit_of(host_wr, reg_addr, ADDR_GAIN_COEFF_SET1); // [R08] [R09]
    assign h_g2 = hit_of(host_wr, reg_addr, ADDR_GAIN_COEFF_SET2); // [R08] [R09]
    assign h_o1 = hit_of(host_wr, reg_addr, ADDR_OFS1);  // [R01] [R04]
    assign h_o2 = hit_of(host_wr, reg_addr, ADDR_OFS2);  // [R01] [R04]

    // ----------------------------------------------------------------
    // calibration routing
    // ----------------------------------------------------------------
    // a calibration result goes to the set selected in the cycle it arrives
    wire logic             cur_set2;
    wire logic             cal_set1;
    wire logic             cal_set2;
    wire logic [REG_W-1:0] cal_word;
    assign cur_set2 = set2_of(positive_input_select); // [R06]
    assign cal_set1 = cal_ofs_valid & ~cur_set2;      // [R02]
    assign cal_set2 = cal_ofs_valid & cur_set2;       // [R02]
    assign cal_word = sext_ofs(cal_ofs_value);        // [R03]

    // ----------------------------------------------------------------
    // write ports of the stores
    // ----------------------------------------------------------------
    ccr_wr_if g1_wr ();
    ccr_wr_if g2_wr ();
    ccr_wr_if o1_wr ();
    ccr_wr_if o2_wr ();

    assign g1_wr.en   = h_g1;
    assign g1_wr.data = reg_wdata;
    assign g2_wr.en   = h_g2;
    assign g2_wr.data = reg_wdata;
    // host and calibration in one cycle: host wins, it is the later intent
    assign o1_wr.en   = h_o1 | cal_set1; // [R02]
    assign o1_wr.data = h_o1 ? reg_wdata : cal_word;
    assign o2_wr.en   = h_o2 | cal_set2; // [R02]
    assign o2_wr.data = h_o2 ? reg_wdata : cal_word;

    // ----------------------------------------------------------------
    // coefficient stores
    // ----------------------------------------------------------------
    logic [REG_W-1:0] gain_coeff_set1;
    logic [REG_W-1:0] gain_coeff_set2;
    logic [REG_W-1:0] ofs1;
    logic [REG_W-1:0] ofs2;

    // gain stores keep only the unsigned field, the top bits read as zero
    ccr_coeff_store #(.VAL_W(GAIN_W), .SIGNED(1'b0)) u_g1 (
        .clock (clock),
        .rst   (rst),
        .wr    (g1_wr.dst),
        .value (gain_coeff_set1)
    ); // [R08]
    ccr_coeff_store #(.VAL_W(GAIN_W), .SIGNED(1'b0)) u_g2 (
        .clock (clock),
        .rst   (rst),
        .wr    (g2_wr.dst),
        .value (gain_coeff_set2)
    ); // [R08]
    // offset stores keep the signed field, the top bits repeat its sign
    ccr_coeff_store #(.VAL_W(OFS_W), .SIGNED(1'b1)) u_o1 (
        .clock (clock),
        .rst   (rst),
        .wr    (o1_wr.dst),
        .value (ofs1)
    ); // [R01]
    ccr_coeff_store #(.VAL_W(OFS_W), .SIGNED(1'b1)) u_o2 (
        .clock (clock),
        .rst   (rst),
        .wr    (o2_wr.dst),
        .value (ofs2)
    ); // [R01]

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    // unmapped addresses read zero rather than aliasing a store
    wire logic rd_g1;
    wire logic rd_g2;
    wire logic rd_o1;
    wire logic rd_o2;
    assign rd_g1 = (reg_addr == ADDR_GAIN_COEFF_SET1);
    assign rd_g2 = (reg_addr == ADDR_GAIN_COEFF_SET2);
    assign rd_o1 = (reg_addr == ADDR_OFS1);
    assign rd_o2 = (reg_addr == ADDR_OFS2);

    wire logic [REG_W-1:0] rdata_d;
    assign rdata_d = rd_g1 ? gain_coeff_set1 :
                     rd_g2 ? gain_coeff_set2 :
                     rd_o1 ? ofs1  :
                     rd_o2 ? ofs2  :
                     COEFF_RESET;

    // ----------------------------------------------------------------
    // set selection
    // ----------------------------------------------------------------
    // the pair follows the select field with one cycle of latency
    wire logic [REG_W-1:0] gain_d;
    wire logic [REG_W-1:0] ofs_d;
    assign gain_d = cur_set2 ? gain_coeff_set2 : gain_coeff_set1; // [R07]
    assign ofs_d  = cur_set2 ? ofs2  : ofs1;  // [R07]

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    // every output is a flop, so read data lags the address by one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= COEFF_RESET;
        end else begin
            reg_rdata <= rdata_d; // [R01] [R08]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_gain <= COEFF_RESET;
        end else begin
            sel_gain <= gain_d; // [R07]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_offset <= COEFF_RESET;
        end else begin
            sel_offset <= ofs_d; // [R07]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_set2 <= 1'b0;
        end else begin
            sel_set2 <= cur_set2; // [R06]
        end
    end
endmodule : ccr_bank
`default_nettype wire

//--- verif/ccr_bank_properties.sv
// port assertions for the coefficient register bank
`timescale 1ns/10ps
`default_nettype none
module ccr_bank_properties (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        osc_running,
    input wire logic        cal_ofs_valid,
    input wire logic        sel_set2,
    input wire logic [3:0]  reg_addr,
    input wire logic [2:0]  positive_input_select,
    input wire logic [19:0] cal_ofs_value,
    input wire logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata,
    input wire logic [23:0] sel_gain,
    input wire logic [23:0] sel_offset
);
    wire logic s2 = positive_input_select == 3'h2 || positive_input_select == 3'h3;
    wire logic w  = reg_wr && osc_running;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_SET: assert property (!$past(rst) |->
        sel_set2 == ($past(positive_input_select) inside {3'h2, 3'h3})) else $error("set");
    AST_GTOP: assert property (sel_gain[23:18] == 6'h00) else $error("gain top");
    AST_OSGN: assert property (sel_offset[23:20] == {4{sel_offset[19]}}) else $error("sign");
    AST_OWR: assert property (w && reg_addr == 4'hc ##1 reg_addr == 4'hc |=>
        reg_rdata == {{4{$past(reg_wdata[19], 2)}}, $past(reg_wdata[19:0], 2)}) else $error("ofs");
    AST_OGATE: assert property (reg_wr && !osc_running && !cal_ofs_valid && reg_addr == 4'hc
        ##1 reg_addr == 4'hc |=> $stable(reg_rdata)) else $error("ofs gate");
    AST_GGATE: assert property (reg_wr && !osc_running && reg_addr == 4'h8
        ##1 reg_addr == 4'h8 |=> $stable(reg_rdata)) else $error("gain gate");
    AST_CAL: assert property (cal_ofs_valid && !s2 && !(reg_wr && reg_addr == 4'hc) ##1 !s2 |=>
        sel_offset == {{4{$past(cal_ofs_value[19], 2)}}, $past(cal_ofs_value, 2)}) else $error("cal");
    AST_GSEL: assert property (w && reg_addr == 4'h9 ##1 s2 |=>
        sel_gain == {6'h00, $past(reg_wdata[17:0], 2)}) else $error("gain sel");
    cover property (cal_ofs_valid && s2);
    cover property (w && reg_addr == 4'hd);
    cover property (reg_wr && !osc_running);
endmodule : ccr_bank_properties
bind ccr_bank ccr_bank_properties u_chk (
    .clock                 (clock),
    .rst                   (rst),
    .reg_wr                (reg_wr),
    .osc_running           (osc_running),
    .cal_ofs_valid         (cal_ofs_valid),
    .sel_set2              (sel_set2),
    .reg_addr              (reg_addr),
    .positive_input_select (positive_input_select),
    .cal_ofs_value         (cal_ofs_value),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .sel_gain              (sel_gain),
    .sel_offset            (sel_offset)
);
`default_nettype wire

//--- verif/ccr_host.sv
// host model: writes coefficients over the register port
`timescale 1ns/10ps
`default_nettype none
module ccr_host (
    input  wire logic   clock,
    output logic [3:0]  reg_addr = 4'h0,
    output logic        reg_wr = 1'b0,
    output logic [23:0] reg_wdata = 24'h0
);
    bit auto_sleep_control = 1'b1;
    // address is held after the write so the bench can read it back
    task automatic wr(logic [3:0] a, logic [23:0] d, logic go);
        auto_sleep_control = 1'b0;
        @(negedge clock);
        {reg_addr, reg_wdata, reg_wr} = {a, d, go};
        @(negedge clock);
        {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask : wr
endmodule : ccr_host
`default_nettype wire

//--- verif/calib_coeff_registers_tb.sv
// bench for the coefficient register bank: random writes and calibration loads
`timescale 1ns/10ps
`default_nettype none
module calib_coeff_registers_tb;
    logic        clock = 0, rst = 1, osc_running = 1, cal_ofs_valid = 0, sel_set2, reg_wr, e2;
    logic [3:0]  reg_addr, amap [5] = '{4'h8, 4'h9, 4'hc, 4'hd, 4'h3};
    logic [2:0]  positive_input_select = 0;
    logic [19:0] cal_ofs_value = 0, v;
    logic [23:0] reg_wdata, reg_rdata, sel_gain, sel_offset, d, m [5] = '{default: 24'h0};
    int          error_cnt = 0, checked = 0, cyc = 0, seed = 80, k = 4;
    ccr_bank u_dut (
        .clock                 (clock),
        .rst                   (rst),
        .reg_addr              (reg_addr),
        .reg_wr                (reg_wr),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata),
        .osc_running           (osc_running),
        .positive_input_select (positive_input_select),
        .cal_ofs_valid         (cal_ofs_valid),
        .cal_ofs_value         (cal_ofs_value),
        .sel_gain              (sel_gain),
        .sel_offset            (sel_offset),
        .sel_set2              (sel_set2)
    );
    ccr_host u_host (
        .clock     (clock),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata)
    );
    function automatic logic [23:0] fmt(int i, logic [23:0] x);
        return i < 2 ? {6'h00, x[17:0]} : {{4{x[19]}}, x[19:0]};
    endfunction : fmt
    task automatic chk(string n, logic [23:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_bit(string n, logic e, logic g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task summarize;
        if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial forever #5 clock = ~clock;
    always @(posedge clock) if (++cyc == 1000) begin
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (16) @(negedge clock);
        rst = 0;
        for (int i = 0; i < 5; i++) begin
            u_host.wr(amap[i], 24'hffffff, 1'b0);
            @(negedge clock);
            chk("reset", 24'h0, reg_rdata);
        end
        for (int i = 0; i < 45; i++) begin
            d = i ? 24'($random(seed)) : 24'h080000;
            if (i % 3 == 2) begin
                v = 20'($random(seed));
                positive_input_select = 3'(i / 3);
                {cal_ofs_valid, cal_ofs_value} = {1'b1, v};
                @(negedge clock);
                {cal_ofs_valid, cal_ofs_value} = {1'b0, ~v};
                m[(positive_input_select inside {3'h2, 3'h3}) + 2] = fmt(2, {4'h0, v});
            end else begin
                k = i ? {$random(seed)} % 5 : 2;
                osc_running = i < 4 || $random(seed) % 3;
                u_host.wr(amap[k], d, 1'b1);
                if (osc_running && k < 4) m[k] = fmt(k, d);
            end
            @(negedge clock);
            e2 = positive_input_select inside {3'h2, 3'h3};
            chk("readback", m[k], reg_rdata);
            chk_bit("set", e2, sel_set2);
            chk("gain", m[e2], sel_gain);
            chk("offset", m[e2 + 2], sel_offset);
        end
        summarize;
    end
endmodule : calib_coeff_registers_tb
`default_nettype wire
